// >>> logic/audio_clock_source_select.v
`default_nettype none
`include "clksel_defines.vh"
// ****************************************************************
// Clock source selection with an APB register slave.
// ****************************************************************
module audio_clock_source_select (
  // Clock, reset and enable.
  input wire mclk_i,
  input wire reset_n_i,
  input wire ce_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Interface frame and bit clock pins (slave mode inputs).
  input wire primary_rx_frame_pin_i,
  input wire primary_rx_bit_pin_i,
  input wire primary_tx_frame_pin_i,
  input wire primary_tx_bit_pin_i,
  input wire secondary_frame_pin_i,
  input wire secondary_bit_pin_i,
  // Effective multiplexer selects, codes per SRC_ constants.
  output reg [1:0] converter_clock_effective_select_o,
  output reg [1:0] adc_clock_effective_select_o,
  output reg [1:0] transmit_clock_effective_select_o,
  output reg [1:0] primary_rx_master_select_o,
  output reg [1:0] primary_tx_master_select_o,
  output reg [1:0] secondary_if_master_select_o,
  // Frame and bit clock source: high means generated internally.
  output reg primary_rx_clocks_internal_o,
  output reg primary_tx_clocks_internal_o,
  output reg secondary_clocks_internal_o,
  // Synchronised pin frame clocks that pace each interface's rate in slave mode; held low in master mode.
  output reg primary_rx_rate_frame_o,
  output reg primary_tx_rate_frame_o,
  output reg secondary_rate_frame_o
);

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  reg [5:0] clksel_ff; // Converter, ADC and transmitter fields.
  reg [3:0] primary_audio_interface_ff; // Primary transmit [1:0] and receive [3:2].
  reg [1:0] secondary_audio_interface_ff; // Secondary interface source field.
  reg manual_clock_override_ff; // Bypasses routing protection.
  reg [5:0] route_ff; // Routing and master-mode controls.
  reg [1:0] nxt_conv;
  reg [1:0] nxt_adc;
  reg [1:0] nxt_tx;
  reg [1:0] nxt_prx;
  reg [1:0] nxt_ptx;
  reg [1:0] nxt_secondary_audio_interface;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  wire setup_w = psel_i && !penable_i; // Setup phase of a transfer.
  wire access_w = psel_i && penable_i && pready_o; // Completing edge.
  wire rx_enabled_w = route_ff[`ROUTE_RXEN_BIT];
  wire [1:0] dac_route_w = route_ff[`ROUTE_DAC_LSB+1:`ROUTE_DAC_LSB];
  wire dac_from_rx_w = (dac_route_w == `DAC_FROM_RECEIVER);
  wire auto_w = !manual_clock_override_ff;
  wire [2:0] sync_frames_w;
  wire [2:0] sync_bits_w;
  wire [1:0] dec_conv_w;
  wire [1:0] dec_adc_w;
  wire [1:0] dec_tx_w;
  wire [1:0] dec_prx_w;
  wire [1:0] dec_ptx_w;
  wire [1:0] dec_secondary_audio_interface_w;

  // Checks that an address is one of the mapped words.
  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr == `REG_CLKSEL_ADDR) || (addr == `REG_PRIMARY_AUDIO_INTERFACE_ADDR) ||
               (addr == `REG_SECONDARY_AUDIO_INTERFACE_ADDR) || (addr == `REG_MANUAL_ADDR) ||
               (addr == `REG_ROUTE_ADDR) || (addr == `REG_EFFECTIVE_ADDR);
    end
  endfunction

  // ****************************************************************
  // APB slave: no wait states, pready rises in the first access-phase cycle.
  // ****************************************************************
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = !mapped(paddr_i);
    case (paddr_i)
      `REG_CLKSEL_ADDR: nxt_rdata = {26'h0000000, clksel_ff};
      `REG_PRIMARY_AUDIO_INTERFACE_ADDR: nxt_rdata = {24'h000000, primary_audio_interface_ff, 4'h0};
      `REG_SECONDARY_AUDIO_INTERFACE_ADDR: nxt_rdata = {24'h000000, secondary_audio_interface_ff, 6'h00};
      `REG_MANUAL_ADDR:
        nxt_rdata = {25'h0000000, manual_clock_override_ff, 6'h00};
      `REG_ROUTE_ADDR: nxt_rdata = {26'h0000000, route_ff};
      `REG_EFFECTIVE_ADDR: begin
        nxt_rdata = {20'h00000, secondary_if_master_select_o,
                     primary_tx_master_select_o,
                     primary_rx_master_select_o,
                     transmit_clock_effective_select_o,
                     adc_clock_effective_select_o,
                     converter_clock_effective_select_o};
      end
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Handles the bus handshake and register writes.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
      clksel_ff <= `CLKSEL_RESET;
      primary_audio_interface_ff <= `PRIMARY_AUDIO_INTERFACE_RESET;
      secondary_audio_interface_ff <= `SECONDARY_AUDIO_INTERFACE_RESET;
      manual_clock_override_ff <= 1'b0;
      route_ff <= `ROUTE_RESET;
    end else if (ce_i) begin
      // Ready is raised at the setup edge and dropped after completion.
      pready_o <= setup_w;
      if (setup_w) begin
        prdata_o <= pwrite_i ? 32'h00000000 : nxt_rdata;
        pslverr_o <= nxt_err;
      end else if (access_w) begin
        pslverr_o <= 1'b0;
      end
      // Writes take effect at the completing edge only.
      if (access_w && pwrite_i) begin
        case (paddr_i)
          `REG_CLKSEL_ADDR: clksel_ff <= pwdata_i[5:0];
          `REG_PRIMARY_AUDIO_INTERFACE_ADDR: primary_audio_interface_ff <= pwdata_i[7:4];
          `REG_SECONDARY_AUDIO_INTERFACE_ADDR: secondary_audio_interface_ff <= pwdata_i[7:6];
          `REG_MANUAL_ADDR:
            manual_clock_override_ff <= pwdata_i[`MANUAL_BIT];
          `REG_ROUTE_ADDR: route_ff <= pwdata_i[5:0];
          default: clksel_ff <= clksel_ff;
        endcase
      end
    end
  end

  // ****************************************************************
  // Field decoding.
  // ****************************************************************
  // Converter: code 3 maps to the system clock, never to the pin.
  sel_decode u_dec_conv (
    .field_i(clksel_ff[1:0]),
    .plls_blocked_i(1'b0),
    .is_adc_i(1'b0),
    .source_o(dec_conv_w)
  );

  // ADC: PLL outputs withheld while the receiver runs, unless manual.
  sel_decode u_dec_adc (
    .field_i(clksel_ff[3:2]),
    .plls_blocked_i(rx_enabled_w && auto_w),
    .is_adc_i(1'b1),
    .source_o(dec_adc_w)
  );

  // Serial audio transmitter.
  sel_decode u_dec_tx (
    .field_i(clksel_ff[5:4]),
    .plls_blocked_i(1'b0),
    .is_adc_i(1'b0),
    .source_o(dec_tx_w)
  );

  // Primary receive master source.
  sel_decode u_dec_prx (
    .field_i(primary_audio_interface_ff[3:2]),
    .plls_blocked_i(1'b0),
    .is_adc_i(1'b0),
    .source_o(dec_prx_w)
  );

  // Primary transmit master source.
  sel_decode u_dec_ptx (
    .field_i(primary_audio_interface_ff[1:0]),
    .plls_blocked_i(1'b0),
    .is_adc_i(1'b0),
    .source_o(dec_ptx_w)
  );

  // Secondary interface master source, both directions.
  sel_decode u_dec_secondary_audio_interface (
    .field_i(secondary_audio_interface_ff),
    .plls_blocked_i(1'b0),
    .is_adc_i(1'b0),
    .source_o(dec_secondary_audio_interface_w)
  );

  // Combines decoded fields with routing.
  always @* begin
    nxt_conv = dec_conv_w;
    if (auto_w && dac_from_rx_w) begin
      nxt_conv = `SRC_PLLA;
    end
    nxt_adc = dec_adc_w;
    nxt_tx = dec_tx_w;
    if (auto_w && rx_enabled_w && dec_tx_w != `SRC_MCLK) begin
      nxt_tx = `SRC_PLLA;
    end
    nxt_prx = dec_prx_w;
    nxt_ptx = dec_ptx_w;
    nxt_secondary_audio_interface = dec_secondary_audio_interface_w;
  end

  // ****************************************************************
  // Pin synchronisers for slave-mode frame and bit clocks.
  // ****************************************************************
  sync2 #(.WIDTH(6)) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i({secondary_bit_pin_i, primary_tx_bit_pin_i, primary_rx_bit_pin_i,
          secondary_frame_pin_i, primary_tx_frame_pin_i,
          primary_rx_frame_pin_i}),
    .q_o({sync_bits_w, sync_frames_w})
  );

  // ****************************************************************
  // Registered outputs, recomputed every enabled cycle.
  // ****************************************************************
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      converter_clock_effective_select_o <= `SRC_MCLK;
      adc_clock_effective_select_o <= `SRC_CONV;
      transmit_clock_effective_select_o <= `SRC_MCLK;
      primary_rx_master_select_o <= `SRC_MCLK;
      primary_tx_master_select_o <= `SRC_MCLK;
      secondary_if_master_select_o <= `SRC_MCLK;
      primary_rx_clocks_internal_o <= 1'b0;
      primary_tx_clocks_internal_o <= 1'b0;
      secondary_clocks_internal_o <= 1'b0;
      primary_rx_rate_frame_o <= 1'b0;
      primary_tx_rate_frame_o <= 1'b0;
      secondary_rate_frame_o <= 1'b0;
    end else if (ce_i) begin
      converter_clock_effective_select_o <= nxt_conv;
      adc_clock_effective_select_o <= nxt_adc;
      transmit_clock_effective_select_o <= nxt_tx;
      primary_rx_master_select_o <= nxt_prx;
      primary_tx_master_select_o <= nxt_ptx;
      secondary_if_master_select_o <= nxt_secondary_audio_interface;
      primary_rx_clocks_internal_o <= route_ff[`ROUTE_PRX_MASTER_BIT];
      primary_tx_clocks_internal_o <= route_ff[`ROUTE_PTX_MASTER_BIT];
      secondary_clocks_internal_o <= route_ff[`ROUTE_SECONDARY_AUDIO_INTERFACE_MASTER_BIT];
      // Slave-mode rate follows the pin frame clock; master drives low.
      primary_rx_rate_frame_o <= !route_ff[`ROUTE_PRX_MASTER_BIT] &&
                                 sync_frames_w[0];
      primary_tx_rate_frame_o <= !route_ff[`ROUTE_PTX_MASTER_BIT] &&
                                 sync_frames_w[1];
      secondary_rate_frame_o <= !route_ff[`ROUTE_SECONDARY_AUDIO_INTERFACE_MASTER_BIT] &&
                                sync_frames_w[2];
    end
  end

  // Bit clocks are synchronised for completeness; the rate generator
  // only needs frame clocks, so they are sampled but unused here.
  wire unused_bits_w = ^sync_bits_w;

endmodule // audio_clock_source_select
`default_nettype wire

// >>> logic/sel_decode.v
`default_nettype none
// ****************************************************************
// Maps a two-bit request field to a source code, with a clamp.
// ****************************************************************
module sel_decode (
  // Request.
  input wire [1:0] field_i,
  input wire plls_blocked_i,
  input wire is_adc_i,
  // Result.
  output reg [1:0] source_o
);
  `include "clksel_defines.vh"

  // Decodes the field and removes the PLL outputs when blocked.
  always @* begin
    case (field_i)
      2'h0: source_o = is_adc_i ? `SRC_CONV : `SRC_MCLK;
      // PLL codes name the post-divider outputs, never the oscillator.
      2'h1: source_o = `SRC_PLLA;
      2'h2: source_o = `SRC_PLLB;
      default: source_o = `SRC_MCLK;
    endcase
    if (plls_blocked_i &&
        (source_o == `SRC_PLLA || source_o == `SRC_PLLB)) begin
      source_o = is_adc_i ? `SRC_CONV : `SRC_MCLK;
    end
  end
endmodule // sel_decode
`default_nettype wire

// >>> logic/sync2.v
`default_nettype none
// ****************************************************************
// Two-flop synchroniser for pin inputs.
// ****************************************************************
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input wire mclk_i,
  input wire reset_n_i,
  input wire ce_i,
  // Data.
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_ff; // First stage, read only by q_o.

  // Samples the asynchronous level through two stages.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_ff <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule // sync2
`default_nettype wire

// >>> pkg/clksel_defines.vh
`ifndef CLKSEL_DEFINES_VH
`define CLKSEL_DEFINES_VH
// Register byte addresses on the APB bus.
`define REG_CLKSEL_ADDR 12'h020
`define REG_PRIMARY_AUDIO_INTERFACE_ADDR 12'h024
`define REG_SECONDARY_AUDIO_INTERFACE_ADDR 12'h02C
`define REG_MANUAL_ADDR 12'h018
`define REG_ROUTE_ADDR 12'h030
`define REG_EFFECTIVE_ADDR 12'h034
// Register word indices.
`define REG_CLKSEL_INDEX 8
`define REG_PRIMARY_AUDIO_INTERFACE_INDEX 9
`define REG_SECONDARY_AUDIO_INTERFACE_INDEX 11
`define REG_MANUAL_INDEX 6
// Field positions.
`define DAC_SEL_LSB 0
`define ADC_SEL_LSB 2
`define TX_SEL_LSB 4
`define PRX_SEL_LSB 6
`define PTX_SEL_LSB 4
`define SECONDARY_AUDIO_INTERFACE_SEL_LSB 6
`define MANUAL_BIT 6
`define ROUTE_DAC_LSB 0
`define ROUTE_RXEN_BIT 2
`define ROUTE_PRX_MASTER_BIT 3
`define ROUTE_PTX_MASTER_BIT 4
`define ROUTE_SECONDARY_AUDIO_INTERFACE_MASTER_BIT 5
// Reset values.
`define CLKSEL_RESET 6'h00
`define PRIMARY_AUDIO_INTERFACE_RESET 4'h0
`define SECONDARY_AUDIO_INTERFACE_RESET 2'h0
`define ROUTE_RESET 6'h03
// Source codes for the effective selects.
`define SRC_MCLK 2'h0
`define SRC_PLLA 2'h1
`define SRC_PLLB 2'h2
`define SRC_CONV 2'h3
// Routing code for converter fed from the serial audio receiver.
`define DAC_FROM_RECEIVER 2'h0
`endif

// >>> tb/audio_clock_source_select_monitor.sv
`default_nettype none
`include "clksel_defines.vh"
module audio_clock_source_select_monitor (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Bus.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // Selects and interface state.
  input wire logic [1:0] converter_clock_effective_select_o,
  input wire logic [1:0] adc_clock_effective_select_o,
  input wire logic primary_rx_clocks_internal_o,
  input wire logic primary_tx_clocks_internal_o,
  input wire logic secondary_clocks_internal_o,
  input wire logic primary_rx_rate_frame_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Shadow copies of the routing and override registers.
  // ****************************************************************
  logic [5:0] route_ff; // Routing word as last written.
  logic man_ff; // Manual override as last written.
  // Follows completed writes so the checks know the configuration.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      route_ff <= `ROUTE_RESET;
      man_ff <= 1'b0;
    end else if (psel_i && penable_i && pready_o && pwrite_i) begin
      if (paddr_i == `REG_ROUTE_ADDR) route_ff <= pwdata_i[5:0];
      if (paddr_i == `REG_MANUAL_ADDR) man_ff <= pwdata_i[`MANUAL_BIT];
    end
  end
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rdy_access;
    pready_o |-> psel_i && penable_i;
  endproperty
  property p_rdy_answer;
    psel_i && !penable_i && ce_i |=> pready_o;
  endproperty
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_conv_range;
    converter_clock_effective_select_o != `SRC_CONV;
  endproperty
  property p_conv_force;
    (route_ff[1:0] == `DAC_FROM_RECEIVER && !man_ff)[*3]
      |-> converter_clock_effective_select_o == `SRC_PLLA;
  endproperty
  property p_adc_no_pll;
    (route_ff[`ROUTE_RXEN_BIT] && !man_ff)[*3]
      |-> adc_clock_effective_select_o != `SRC_PLLA
        && adc_clock_effective_select_o != `SRC_PLLB;
  endproperty
  property p_master_mode;
    $stable(route_ff)[*3] |-> {secondary_clocks_internal_o,
      primary_tx_clocks_internal_o, primary_rx_clocks_internal_o}
      == route_ff[5:3];
  endproperty
  property p_rate_master;
    primary_rx_clocks_internal_o[*4] |-> !primary_rx_rate_frame_o;
  endproperty
  a_rdy_access: assert property (p_rdy_access)
    else $error("ready outside an access phase");
  a_rdy_answer: assert property (p_rdy_answer)
    else $error("no answer after setup");
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready held too long");
  a_conv_range: assert property (p_conv_range)
    else $error("converter clock from a forbidden source");
  a_conv_force: assert property (p_conv_force)
    else $error("receiver-fed converter not on PLL A");
  a_adc_no_pll: assert property (p_adc_no_pll)
    else $error("PLL offered to ADC with receiver on");
  a_master_mode: assert property (p_master_mode)
    else $error("master mode flags disagree with routing");
  a_rate_master: assert property (p_rate_master)
    else $error("pin frame clock used in master mode");
  c_force: cover property (route_ff[1:0] == 2'h0 && !man_ff);
  c_manual: cover property (man_ff && route_ff[1:0] == 2'h0);
  c_rxen: cover property (route_ff[`ROUTE_RXEN_BIT]);
endmodule // audio_clock_source_select_monitor
bind audio_clock_source_select audio_clock_source_select_monitor u_mon (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o),
  .converter_clock_effective_select_o(converter_clock_effective_select_o),
  .adc_clock_effective_select_o(adc_clock_effective_select_o),
  .primary_rx_clocks_internal_o(primary_rx_clocks_internal_o),
  .primary_tx_clocks_internal_o(primary_tx_clocks_internal_o),
  .secondary_clocks_internal_o(secondary_clocks_internal_o),
  .primary_rx_rate_frame_o(primary_rx_rate_frame_o));
`default_nettype wire

// >>> tb/audio_clock_source_select_tb.sv
`default_nettype none
`include "clksel_defines.vh"
module audio_clock_source_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fr = 1'b0, perr, pready, err_seen;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] cs, as, ts, rs, xs, ss;
  logic [2:0] intl, rate;
  int err_count = 0, n_compared = 0;
  always #5 mclk = ~mclk; // The clock toggles every half period.
  audio_clock_source_select u_audio_clock_source_select (
    .mclk_i(mclk), .reset_n_i(reset_n), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .primary_rx_frame_pin_i(fr),
    .primary_rx_bit_pin_i(fr), .primary_tx_frame_pin_i(fr),
    .primary_tx_bit_pin_i(fr), .secondary_frame_pin_i(fr),
    .secondary_bit_pin_i(fr), .converter_clock_effective_select_o(cs),
    .adc_clock_effective_select_o(as),
    .transmit_clock_effective_select_o(ts),
    .primary_rx_master_select_o(rs), .primary_tx_master_select_o(xs),
    .secondary_if_master_select_o(ss),
    .primary_rx_clocks_internal_o(intl[0]),
    .primary_tx_clocks_internal_o(intl[1]),
    .secondary_clocks_internal_o(intl[2]),
    .primary_rx_rate_frame_o(rate[0]), .primary_tx_rate_frame_o(rate[1]),
    .secondary_rate_frame_o(rate[2]));
  // ****************************************************************
  // Bus and checking tasks.
  // ****************************************************************
  // One APB transfer; the answer is taken at the edge where ready is seen.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Ready, read data and the error flag are sampled at the rising edge.
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(negedge mclk); // Lets the selects settle.
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    apb(0, `REG_EFFECTIVE_ADDR, 0); chk(rd, 32'h0000000C);
    apb(0, `REG_ROUTE_ADDR, 0); chk(rd, 32'h00000003);
    apb(1, 12'h0FC, 32'hFFFFFFFF); chk(32'(err_seen), 32'h1);
    apb(0, 12'h0FC, 0); chk(rd, 32'h0);
    // Every field code on the three request fields.
    for (int f = 0; f < 4; f++) begin
      apb(1, `REG_CLKSEL_ADDR, 32'(f * 8'h15));
      apb(0, `REG_CLKSEL_ADDR, 0); chk(rd, 32'(f * 8'h15));
      chk(32'(cs), (f == 3) ? 0 : f);
      chk(32'(as), (f == 0) ? 3 : (f == 3) ? 0 : f);
      chk(32'(ts), (f == 3) ? 0 : f);
    end
    apb(1, `REG_ROUTE_ADDR, 32'h0);
    apb(1, `REG_CLKSEL_ADDR, 32'h2);
    chk(32'(cs), 32'(`SRC_PLLA));
    apb(1, `REG_MANUAL_ADDR, 32'h40);
    chk(32'(cs), 32'(`SRC_PLLB));
    apb(1, `REG_MANUAL_ADDR, 32'h0);
    apb(1, `REG_ROUTE_ADDR, 32'h7);
    apb(1, `REG_CLKSEL_ADDR, 32'h24);
    chk(32'(as === `SRC_PLLA || as === `SRC_PLLB), 32'h0);
    chk(32'(ts), 32'(`SRC_PLLA));
    // Master mode on all three interfaces, then back to slave.
    apb(1, `REG_PRIMARY_AUDIO_INTERFACE_ADDR, 32'h60);
    apb(1, `REG_SECONDARY_AUDIO_INTERFACE_ADDR, 32'hC0);
    apb(1, `REG_ROUTE_ADDR, 32'h3B);
    chk({26'h0, rs, xs, ss}, 32'h18);
    chk(32'(intl), 32'h7);
    @(posedge mclk);
    fr <= 1'b1;
    repeat (6) @(negedge mclk);
    chk(32'(rate), 32'h0);
    apb(1, `REG_ROUTE_ADDR, 32'h3);
    chk(32'(intl), 32'h0);
    chk(32'(rate), 32'h7);
    final_report();
  end
endmodule // audio_clock_source_select_tb
`default_nettype wire
